// ==== include/lpddr_bank_pkg.sv ====
`default_nettype none
package lpddr_bank_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int NS_SCALE = 1000;
  localparam int WRITE_RECOVERY_TIME_NS = 15;
  localparam int PRECHARGE_PERIOD_NS = 20;
  localparam int MIN_ROW_ACTIVE_TIME_NS = 40;

  // Least times, rounded up to whole cycles
  localparam int WR_RAW = (WRITE_RECOVERY_TIME_NS * CLK_MHZ + NS_SCALE - 1) / NS_SCALE;
  localparam int RP_RAW = (PRECHARGE_PERIOD_NS * CLK_MHZ + NS_SCALE - 1) / NS_SCALE;
  localparam int RAS_RAW = (MIN_ROW_ACTIVE_TIME_NS * CLK_MHZ + NS_SCALE - 1) / NS_SCALE;
  localparam logic [7:0] WRITE_RECOVERY_CYC = 8'((WR_RAW < 1) ? 1 : WR_RAW);
  localparam logic [7:0] PRECHARGE_PERIOD_CYC = 8'((RP_RAW < 1) ? 1 : RP_RAW);
  localparam logic [7:0] MIN_ROW_ACTIVE_CYC = 8'((RAS_RAW < 1) ? 1 : RAS_RAW);

  // ----------------------------------------------------------------
  // Structure and reset values
  // ----------------------------------------------------------------
  localparam int NUM_BANKS = 4;
  localparam int LANE_BITS = 8;
  localparam int SLOT_DEPTH = 4;
  localparam int ELEMS_PER_PAIR = 2;
  localparam int BURST_LENGTH_DEFAULT = 4;
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [1:0] PTR_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Command pin encodings {row strobe, column strobe, write enable}
  // ----------------------------------------------------------------
  localparam logic [2:0] PIN_ACTIVATE = 3'h3;
  localparam logic [2:0] PIN_READ = 3'h5;
  localparam logic [2:0] PIN_WRITE = 3'h4;
  localparam logic [2:0] PIN_PRECHARGE = 3'h2;
  localparam logic [2:0] PIN_REFRESH = 3'h1;
  localparam logic [2:0] PIN_NOP = 3'h7;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_AREF, CMD_OTHER
  } cmd_t;

  typedef enum logic [1:0] {
    BANK_IDLE, BANK_ACTIVE, BANK_PRECHARGING
  } bank_state_t;

endpackage : lpddr_bank_pkg
`default_nettype wire

// ==== logic/strobe_pair_capture.sv ====
`default_nettype none
module strobe_pair_capture #(
  parameter int LANE_W = 8
) (
  // Link side
  input wire logic strobe_clk_i,
  input wire logic arst_n_i,
  input wire logic [LANE_W-1:0] data_i,
  input wire logic mask_i,
  // Crossing to the command clock
  output logic [1:0] wr_gray_o,
  output logic [lpddr_bank_pkg::SLOT_DEPTH*(2*LANE_W+2)-1:0] slots_o
);

  localparam int ENTRY_W = 2 * LANE_W + 2;

  logic [LANE_W-1:0] rise_data_r;
  logic rise_mask_r;
  logic [1:0] wr_bin_r;
  logic [1:0] wr_bin_nxt;

  assign wr_bin_nxt = wr_bin_r + 2'h1;

  // ----------------------------------------------------------------
  // First element of a pair on the rising strobe edge
  // ----------------------------------------------------------------
  always_ff @(posedge strobe_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rise_data_r <= '0;
      rise_mask_r <= 1'b1;
    end else begin
      rise_data_r <= data_i;
      rise_mask_r <= mask_i;
    end
  end

  // ----------------------------------------------------------------
  // Second element on the falling edge; pair goes into a slot
  // ----------------------------------------------------------------
  always_ff @(negedge strobe_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      slots_o <= '0;
      wr_bin_r <= lpddr_bank_pkg::PTR_RESET;
      wr_gray_o <= lpddr_bank_pkg::PTR_RESET;
    end else begin
      slots_o[wr_bin_r*ENTRY_W +: ENTRY_W] <= {mask_i, data_i, rise_mask_r, rise_data_r};
      wr_bin_r <= wr_bin_nxt;
      wr_gray_o <= wr_bin_nxt ^ {1'b0, wr_bin_nxt[1]};
    end
  end

endmodule : strobe_pair_capture
`default_nettype wire

// ==== logic/lpddr_write_precharge_refresh.sv ====
`default_nettype none
module lpddr_write_precharge_refresh #(
  parameter int DQ_W = 16,
  parameter int COL_W = 10,
  parameter int ROW_W = 14,
  parameter int BURST_LENGTH = lpddr_bank_pkg::BURST_LENGTH_DEFAULT
) (
  // Command clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // Command pins
  input wire logic chip_select_n_i,
  input wire logic row_strobe_n_i,
  input wire logic col_strobe_n_i,
  input wire logic write_enable_n_i,
  input wire logic clock_enable_i,
  input wire logic bank_select_low_i,
  input wire logic bank_select_high_i,
  input wire logic precharge_select_bit_i,
  input wire logic [COL_W-1:0] col_addr_i,
  // Write data link
  input wire logic [DQ_W/8-1:0] lane_strobe_i,
  input wire logic [DQ_W-1:0] dq_i,
  input wire logic [DQ_W/8-1:0] write_mask_i,
  // Array write port
  output logic arr_we_o,
  output logic [1:0] arr_bank_o,
  output logic [COL_W-1:0] arr_col_o,
  output logic [2*DQ_W-1:0] arr_data_o,
  output logic [2*(DQ_W/8)-1:0] arr_byte_en_o,
  // Refresh and status
  output logic refresh_pulse_o,
  output logic [ROW_W-1:0] refresh_row_o,
  output logic cmd_reject_o,
  output logic [2*lpddr_bank_pkg::NUM_BANKS-1:0] bank_state_o
);

  localparam int LANES = DQ_W / lpddr_bank_pkg::LANE_BITS;
  localparam int LW = lpddr_bank_pkg::LANE_BITS;
  localparam int ENTRY_W = 2 * LW + 2;
  localparam int NB = lpddr_bank_pkg::NUM_BANKS;
  localparam logic [7:0] PAIRS_PER_BURST = 8'(BURST_LENGTH / lpddr_bank_pkg::ELEMS_PER_PAIR);
  localparam logic [7:0] RD_AP_LOAD = PAIRS_PER_BURST - lpddr_bank_pkg::CNT_ONE;
  localparam logic [7:0] WR_AP_LOAD = lpddr_bank_pkg::WRITE_RECOVERY_CYC - lpddr_bank_pkg::CNT_ONE;
  localparam int AP_RD_DLY = BURST_LENGTH / lpddr_bank_pkg::ELEMS_PER_PAIR + 1;
  localparam int AP_WR_DLY = int'(lpddr_bank_pkg::WRITE_RECOVERY_CYC) + 1;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  lpddr_bank_pkg::cmd_t cmd;
  logic [1:0] bank_sel;
  logic is_col;

  assign bank_sel = {bank_select_high_i, bank_select_low_i};
  assign is_col = (cmd == lpddr_bank_pkg::CMD_RD) || (cmd == lpddr_bank_pkg::CMD_WR);

  always_comb begin
    cmd = lpddr_bank_pkg::CMD_NOP;
    if (!chip_select_n_i) begin
      unique case ({row_strobe_n_i, col_strobe_n_i, write_enable_n_i})
        lpddr_bank_pkg::PIN_ACTIVATE: cmd = lpddr_bank_pkg::CMD_ACT;
        lpddr_bank_pkg::PIN_READ: cmd = lpddr_bank_pkg::CMD_RD;
        lpddr_bank_pkg::PIN_WRITE: cmd = lpddr_bank_pkg::CMD_WR;
        lpddr_bank_pkg::PIN_PRECHARGE: cmd = lpddr_bank_pkg::CMD_PRE;
        lpddr_bank_pkg::PIN_REFRESH: begin
          cmd = clock_enable_i ? lpddr_bank_pkg::CMD_AREF : lpddr_bank_pkg::CMD_OTHER;
        end
        lpddr_bank_pkg::PIN_NOP: cmd = lpddr_bank_pkg::CMD_NOP;
        default: cmd = lpddr_bank_pkg::CMD_OTHER;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Write data lanes: strobe domain capture, gray pointer crossing
  // ----------------------------------------------------------------
  logic [LANES-1:0] lane_pend_r;
  logic [ENTRY_W-1:0] lane_entry_r [LANES];
  logic [1:0] sync1_r [LANES];
  logic [1:0] sync2_r [LANES];
  logic [1:0] rd_bin_r [LANES];
  logic [2*DQ_W-1:0] pair_data;
  logic [2*LANES-1:0] pair_mask;
  logic pair_commit;

  assign pair_commit = &lane_pend_r;

  genvar l;
  generate
    for (l = 0; l < LANES; l++) begin : g_lane
      logic [1:0] wr_gray;
      logic [1:0] wr_bin_sync;
      logic [lpddr_bank_pkg::SLOT_DEPTH*ENTRY_W-1:0] slots;
      logic take;

      strobe_pair_capture #(.LANE_W(LW)) u_capture (
        .strobe_clk_i(lane_strobe_i[l]),
        .arst_n_i(arst_n_i),
        .data_i(dq_i[l*LW +: LW]),
        .mask_i(write_mask_i[l]),
        .wr_gray_o(wr_gray),
        .slots_o(slots)
      );

      assign wr_bin_sync = {sync2_r[l][1], sync2_r[l][1] ^ sync2_r[l][0]};
      assign take = (wr_bin_sync != rd_bin_r[l]) && !lane_pend_r[l];

      always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          sync1_r[l] <= lpddr_bank_pkg::PTR_RESET;
          sync2_r[l] <= lpddr_bank_pkg::PTR_RESET;
        end else begin
          sync1_r[l] <= wr_gray;
          sync2_r[l] <= sync1_r[l];
        end
      end

      always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          rd_bin_r[l] <= lpddr_bank_pkg::PTR_RESET;
          lane_pend_r[l] <= 1'b0;
          lane_entry_r[l] <= '0;
        end else if (take) begin
          rd_bin_r[l] <= rd_bin_r[l] + 2'h1;
          lane_pend_r[l] <= 1'b1;
          lane_entry_r[l] <= slots[rd_bin_r[l]*ENTRY_W +: ENTRY_W];
        end else if (pair_commit) begin
          lane_pend_r[l] <= 1'b0;
        end
      end

      // Lane n holds byte n of both elements
      assign pair_data[l*LW +: LW] = lane_entry_r[l][LW-1:0];
      assign pair_data[DQ_W + l*LW +: LW] = lane_entry_r[l][LW+1 +: LW];
      assign pair_mask[l] = lane_entry_r[l][LW];
      assign pair_mask[LANES + l] = lane_entry_r[l][2*LW+1];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Write burst tracking
  // ----------------------------------------------------------------
  logic [NB-1:0] col_ok;
  logic rd_acc;
  logic wr_acc;
  logic trunc_event;
  logic wr_busy_r;
  logic trunc_r;
  logic wr_done_r;
  logic [1:0] wr_bank_r;
  logic [COL_W-1:0] wr_col_r;
  logic [7:0] pairs_left_r;

  assign rd_acc = (cmd == lpddr_bank_pkg::CMD_RD) && (|col_ok);
  assign wr_acc = (cmd == lpddr_bank_pkg::CMD_WR) && (|col_ok);
  assign trunc_event = rd_acc || ((cmd == lpddr_bank_pkg::CMD_PRE) &&
                       (precharge_select_bit_i || (bank_sel == wr_bank_r)));

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_busy_r <= 1'b0;
      trunc_r <= 1'b0;
      wr_done_r <= 1'b0;
      wr_bank_r <= 2'h0;
      wr_col_r <= '0;
      pairs_left_r <= lpddr_bank_pkg::CNT_RESET;
    end else begin
      wr_done_r <= 1'b0;
      if (wr_busy_r && pair_commit) begin
        pairs_left_r <= pairs_left_r - lpddr_bank_pkg::CNT_ONE;
        wr_col_r <= wr_col_r + COL_W'(lpddr_bank_pkg::ELEMS_PER_PAIR);
        if (pairs_left_r == lpddr_bank_pkg::CNT_ONE) begin
          wr_busy_r <= 1'b0;
          wr_done_r <= 1'b1;
        end
      end
      if (wr_busy_r && trunc_event) begin
        trunc_r <= 1'b1;
      end
      if (wr_acc) begin
        wr_busy_r <= 1'b1;
        trunc_r <= 1'b0;
        wr_bank_r <= bank_sel;
        wr_col_r <= col_addr_i;
        pairs_left_r <= PAIRS_PER_BURST;
      end
    end
  end

  // ----------------------------------------------------------------
  // Array write port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      arr_we_o <= 1'b0;
      arr_bank_o <= 2'h0;
      arr_col_o <= '0;
      arr_data_o <= '0;
      arr_byte_en_o <= '0;
    end else begin
      arr_we_o <= wr_busy_r && pair_commit && !trunc_r;
      if (wr_busy_r && pair_commit) begin
        arr_bank_o <= wr_bank_r;
        arr_col_o <= wr_col_r;
        arr_data_o <= pair_data;
        arr_byte_en_o <= ~pair_mask;
      end
    end
  end

  a_trunc_drop: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (trunc_r && wr_busy_r && pair_commit) |=> !arr_we_o)
    else $error("pair stored after write was cut");

  a_mask_map: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (wr_busy_r && !trunc_r && pair_commit) |=>
      (arr_we_o && (arr_byte_en_o == ~$past(pair_mask))))
    else $error("byte enables do not follow the write masks");

  // ----------------------------------------------------------------
  // Per-bank state, precharge and auto precharge
  // ----------------------------------------------------------------
  lpddr_bank_pkg::bank_state_t state_r [NB];
  logic [7:0] rp_cnt_r [NB];
  logic [7:0] ras_cnt_r [NB];
  logic [7:0] ap_cnt_r [NB];
  logic [NB-1:0] ap_arm_r;
  logic [NB-1:0] ap_go_r;
  logic [NB-1:0] act_hit;
  logic [NB-1:0] pre_hit;
  logic [NB-1:0] ras_met;
  logic [NB-1:0] ap_fire;

  genvar b;
  generate
    for (b = 0; b < NB; b++) begin : g_bank
      logic sel;

      assign sel = (bank_sel == 2'(b));
      assign act_hit[b] = (cmd == lpddr_bank_pkg::CMD_ACT) && sel &&
                          (state_r[b] == lpddr_bank_pkg::BANK_IDLE);
      // Idle or already precharging banks ignore it
      assign pre_hit[b] = (cmd == lpddr_bank_pkg::CMD_PRE) &&
                          (precharge_select_bit_i || sel) &&
                          (state_r[b] == lpddr_bank_pkg::BANK_ACTIVE);
      assign col_ok[b] = is_col && sel && !ap_arm_r[b] &&
                         (state_r[b] == lpddr_bank_pkg::BANK_ACTIVE);
      assign ras_met[b] = (ras_cnt_r[b] == lpddr_bank_pkg::MIN_ROW_ACTIVE_CYC);
      assign ap_fire[b] = ap_go_r[b] && (ap_cnt_r[b] == lpddr_bank_pkg::CNT_RESET) &&
                          ras_met[b] && (state_r[b] == lpddr_bank_pkg::BANK_ACTIVE);
      assign bank_state_o[2*b +: 2] = state_r[b];

      always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          state_r[b] <= lpddr_bank_pkg::BANK_IDLE;
          rp_cnt_r[b] <= lpddr_bank_pkg::CNT_RESET;
        end else begin
          unique case (state_r[b])
            lpddr_bank_pkg::BANK_IDLE: begin
              if (act_hit[b]) begin
                state_r[b] <= lpddr_bank_pkg::BANK_ACTIVE;
              end
            end
            lpddr_bank_pkg::BANK_ACTIVE: begin
              if (pre_hit[b] || ap_fire[b]) begin
                state_r[b] <= lpddr_bank_pkg::BANK_PRECHARGING;
                rp_cnt_r[b] <= lpddr_bank_pkg::PRECHARGE_PERIOD_CYC;
              end
            end
            lpddr_bank_pkg::BANK_PRECHARGING: begin
              rp_cnt_r[b] <= rp_cnt_r[b] - lpddr_bank_pkg::CNT_ONE;
              if (rp_cnt_r[b] == lpddr_bank_pkg::CNT_ONE) begin
                state_r[b] <= lpddr_bank_pkg::BANK_IDLE;
              end
            end
          endcase
        end
      end

      // Row active time since the activate, saturating
      always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          ras_cnt_r[b] <= lpddr_bank_pkg::CNT_RESET;
        end else if (act_hit[b]) begin
          ras_cnt_r[b] <= lpddr_bank_pkg::CNT_ONE;
        end else if (!ras_met[b]) begin
          ras_cnt_r[b] <= ras_cnt_r[b] + lpddr_bank_pkg::CNT_ONE;
        end
      end

      always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          ap_arm_r[b] <= 1'b0;
          ap_go_r[b] <= 1'b0;
          ap_cnt_r[b] <= lpddr_bank_pkg::CNT_RESET;
        end else if (pre_hit[b] || ap_fire[b]) begin
          ap_arm_r[b] <= 1'b0;
          ap_go_r[b] <= 1'b0;
        end else if (col_ok[b] && precharge_select_bit_i) begin
          ap_arm_r[b] <= 1'b1;
          ap_go_r[b] <= (cmd == lpddr_bank_pkg::CMD_RD);
          ap_cnt_r[b] <= RD_AP_LOAD;
        end else if (wr_done_r && (wr_bank_r == 2'(b)) && ap_arm_r[b] && !ap_go_r[b]) begin
          ap_go_r[b] <= 1'b1;
          ap_cnt_r[b] <= WR_AP_LOAD;
        end else if (ap_go_r[b] && (ap_cnt_r[b] != lpddr_bank_pkg::CNT_RESET)) begin
          ap_cnt_r[b] <= ap_cnt_r[b] - lpddr_bank_pkg::CNT_ONE;
        end
      end

      sequence s_rd_ap_ready;
        col_ok[b] && (cmd == lpddr_bank_pkg::CMD_RD) && precharge_select_bit_i && ras_met[b];
      endsequence

      sequence s_wr_ap_ready;
        wr_done_r && (wr_bank_r == 2'(b)) && ap_arm_r[b] && !ap_go_r[b] && ras_met[b] &&
        !pre_hit[b] && (state_r[b] == lpddr_bank_pkg::BANK_ACTIVE);
      endsequence

      a_pre_select: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ((cmd == lpddr_bank_pkg::CMD_PRE) && (precharge_select_bit_i || sel) &&
         (state_r[b] == lpddr_bank_pkg::BANK_ACTIVE)) |=>
          ((state_r[b] == lpddr_bank_pkg::BANK_PRECHARGING) &&
           (rp_cnt_r[b] == lpddr_bank_pkg::PRECHARGE_PERIOD_CYC)))
        else $error("precharge did not close the addressed bank");

      a_pre_nop: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ((cmd == lpddr_bank_pkg::CMD_PRE) && (state_r[b] == lpddr_bank_pkg::BANK_PRECHARGING) &&
         (rp_cnt_r[b] != lpddr_bank_pkg::CNT_ONE)) |=>
          ((state_r[b] == lpddr_bank_pkg::BANK_PRECHARGING) &&
           (rp_cnt_r[b] == $past(rp_cnt_r[b]) - lpddr_bank_pkg::CNT_ONE)))
        else $error("precharge restarted a bank already precharging");

      a_pre_idle_nop: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ((cmd == lpddr_bank_pkg::CMD_PRE) && (state_r[b] == lpddr_bank_pkg::BANK_IDLE)) |=>
          (state_r[b] == lpddr_bank_pkg::BANK_IDLE))
        else $error("precharge changed an idle bank");

      a_rp_idle: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ((state_r[b] == lpddr_bank_pkg::BANK_PRECHARGING) &&
         (rp_cnt_r[b] == lpddr_bank_pkg::CNT_ONE)) |=> (state_r[b] == lpddr_bank_pkg::BANK_IDLE))
        else $error("bank not idle at end of precharge period");

      a_ras_lockout: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        ((state_r[b] == lpddr_bank_pkg::BANK_ACTIVE) && !ras_met[b] && !pre_hit[b]) |=>
          (state_r[b] == lpddr_bank_pkg::BANK_ACTIVE))
        else $error("auto precharge before minimum row active time");

      a_rd_ap_time: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        s_rd_ap_ready |-> ##AP_RD_DLY (state_r[b] != lpddr_bank_pkg::BANK_ACTIVE))
        else $error("read auto precharge not started half a burst later");

      a_wr_ap_time: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        s_wr_ap_ready |-> ##AP_WR_DLY (state_r[b] != lpddr_bank_pkg::BANK_ACTIVE))
        else $error("write auto precharge not started after recovery");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Refresh row counter and command rejects
  // ----------------------------------------------------------------
  logic [ROW_W-1:0] row_cnt_r;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      row_cnt_r <= '0;
      refresh_row_o <= '0;
      refresh_pulse_o <= 1'b0;
    end else begin
      refresh_pulse_o <= (cmd == lpddr_bank_pkg::CMD_AREF);
      if (cmd == lpddr_bank_pkg::CMD_AREF) begin
        refresh_row_o <= row_cnt_r;
        row_cnt_r <= row_cnt_r + ROW_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_reject_o <= 1'b0;
    end else begin
      cmd_reject_o <= (is_col && !(|col_ok)) ||
                      ((cmd == lpddr_bank_pkg::CMD_ACT) && !(|act_hit));
    end
  end

  a_col_reject: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (is_col && (state_r[bank_sel] != lpddr_bank_pkg::BANK_ACTIVE)) |=> cmd_reject_o)
    else $error("column access to a closed bank was taken");

  a_refresh_row: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (cmd == lpddr_bank_pkg::CMD_AREF) |=>
      (refresh_pulse_o && (refresh_row_o == $past(row_cnt_r)) &&
       (row_cnt_r == $past(row_cnt_r) + ROW_W'(1))))
    else $error("refresh row not taken from internal counter");

endmodule : lpddr_write_precharge_refresh
`default_nettype wire

// ==== bench/write_link_model.sv ====
`default_nettype none
module write_link_model #(
  parameter int DQ_W = 16,
  parameter int PAIRS = 2
) (
  // Burst request
  input wire logic go_i,
  input wire logic [DQ_W-1:0] base_i,
  input wire logic [2*PAIRS*(DQ_W/8)-1:0] mask_i,
  // Link pins
  output logic [DQ_W/8-1:0] strobe_o,
  output logic [DQ_W-1:0] dq_o,
  output logic [DQ_W/8-1:0] mask_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    strobe_o = '0;
    dq_o = '0;
    mask_o = '0;
  end
  // First rise one clock after the command, data centred on each edge
  always @(posedge go_i) begin
    #17.5;
    for (int k = 0; k < 2 * PAIRS; k++) begin
      dq_o = base_i + DQ_W'(k);
      mask_o = mask_i[k*(DQ_W/8) +: DQ_W/8];
      #7.5;
      strobe_o = ~strobe_o;
      #7.5;
    end
    // Released data and mask lines never hold the last value; the strobe stays at its last level
    dq_o = ~dq_o;
    mask_o = ~mask_o;
  end
endmodule : write_link_model
`default_nettype wire

// ==== bench/lpddr_write_precharge_refresh_tb.sv ====
`default_nettype none
module lpddr_write_precharge_refresh_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [2:0] ACTV = lpddr_bank_pkg::PIN_ACTIVATE;
  localparam logic [2:0] RD = lpddr_bank_pkg::PIN_READ;
  localparam logic [2:0] WR = lpddr_bank_pkg::PIN_WRITE;
  localparam logic [2:0] PRE = lpddr_bank_pkg::PIN_PRECHARGE;
  localparam logic [2:0] REF = lpddr_bank_pkg::PIN_REFRESH;
  localparam int REFRESH_CYCLE_TIME_CYC = 8;
  logic ref_clk_i, arst_n_i, chip_select_n_i, row_strobe_n_i, col_strobe_n_i, go;
  logic write_enable_n_i, clock_enable_i, bank_select_low_i, bank_select_high_i;
  logic precharge_select_bit_i, arr_we_o, refresh_pulse_o, cmd_reject_o;
  logic [1:0] lane_strobe_i, write_mask_i, arr_bank_o;
  logic [3:0] arr_byte_en_o;
  logic [7:0] bank_state_o, masks;
  logic [9:0] col_addr_i, arr_col_o;
  logic [13:0] refresh_row_o;
  logic [15:0] dq_i, base;
  logic [31:0] arr_data_o;
  int fails, comparisons;
  lpddr_write_precharge_refresh lpddr_write_precharge_refresh_i (.ref_clk_i, .arst_n_i,
    .chip_select_n_i, .row_strobe_n_i, .col_strobe_n_i, .write_enable_n_i, .clock_enable_i,
    .bank_select_low_i, .bank_select_high_i, .precharge_select_bit_i, .col_addr_i,
    .lane_strobe_i, .dq_i, .write_mask_i, .arr_we_o, .arr_bank_o, .arr_col_o, .arr_data_o,
    .arr_byte_en_o, .refresh_pulse_o, .refresh_row_o, .cmd_reject_o, .bank_state_o);
  write_link_model write_link_model_i (.go_i(go), .base_i(base), .mask_i(masks),
    .strobe_o(lane_strobe_i), .dq_o(dq_i), .mask_o(write_mask_i));
  always #12.5 ref_clk_i = ~ref_clk_i;
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task cmd(input logic [2:0] p, input logic [1:0] b, input logic a, input logic [9:0] c);
    @(posedge ref_clk_i);
    {row_strobe_n_i, col_strobe_n_i, write_enable_n_i} <= p;
    {bank_select_high_i, bank_select_low_i} <= b;
    precharge_select_bit_i <= a;
    col_addr_i <= c;
    @(posedge ref_clk_i);
    {row_strobe_n_i, col_strobe_n_i, write_enable_n_i} <= lpddr_bank_pkg::PIN_NOP;
  endtask : cmd
  task tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : tick
  task bank_scn;
    cmd(PRE, 2'h1, 1'b0, 10'h000);
    tick(1);
    chk(32'(bank_state_o), 32'h0000_0000, "state");
    cmd(RD, 2'h1, 1'b0, 10'h000);
    tick(0);
    chk(32'(cmd_reject_o), 32'h0000_0001, "reject");
    cmd(ACTV, 2'h1, 1'b0, 10'h000);
    cmd(ACTV, 2'h2, 1'b0, 10'h000);
    cmd(PRE, 2'h1, 1'b0, 10'h000);
    tick(0);
    chk(32'(bank_state_o), 32'h0000_0018, "state");
    tick(1);
    chk(32'(bank_state_o), 32'h0000_0010, "state");
    cmd(PRE, 2'h0, 1'b1, 10'h000);
    tick(0);
    chk(32'(bank_state_o), 32'h0000_0020, "state");
  endtask : bank_scn
  task wait_we(input logic [9:0] col, input logic [31:0] data, input logic [3:0] en);
    int n;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (arr_we_o !== 1'b1 && n < 20);
    chk(32'({arr_we_o, arr_bank_o, arr_col_o}), 32'({1'b1, 2'h0, col}), "commit");
    chk(arr_data_o, data, "data");
    chk(32'(arr_byte_en_o), 32'(en), "lanes");
  endtask : wait_we
  task write_scn;
    base = 16'h3c5a;
    masks = 8'h18;
    cmd(ACTV, 2'h0, 1'b0, 10'h000);
    cmd(WR, 2'h0, 1'b1, 10'h004);
    go <= 1'b1;
    wait_we(10'h004, 32'h3c5b_3c5a, 4'h7);
    wait_we(10'h006, 32'h3c5d_3c5c, 4'he);
    go <= 1'b0;
    tick(1);
    chk(32'(bank_state_o), 32'h0000_0001, "wr auto");
    tick(1);
    chk(32'(bank_state_o), 32'h0000_0002, "wr auto");
    cmd(PRE, 2'h0, 1'b1, 10'h000);
  endtask : write_scn
  task trunc_scn;
    base = 16'h0f0f;
    masks = 8'hff;
    cmd(ACTV, 2'h1, 1'b0, 10'h000);
    cmd(WR, 2'h1, 1'b0, 10'h010);
    go <= 1'b1;
    cmd(PRE, 2'h1, 1'b0, 10'h000);
    repeat (8) begin
      tick(1);
      chk(32'(arr_we_o), 32'h0000_0000, "cut write");
    end
    go <= 1'b0;
  endtask : trunc_scn
  task refresh_scn;
    for (int i = 0; i < 2; i++) begin
      cmd(REF, 2'h3, 1'b1, 10'h3ff);
      tick(0);
      chk(32'({refresh_pulse_o, refresh_row_o}), 32'({1'b1, 14'(i)}), "refresh");
      tick(REFRESH_CYCLE_TIME_CYC);
    end
    clock_enable_i <= 1'b0;
    cmd(REF, 2'h3, 1'b1, 10'h3ff);
    tick(0);
    chk(32'({refresh_pulse_o, refresh_row_o}), 32'h0000_0001, "no refresh");
    clock_enable_i <= 1'b1;
  endtask : refresh_scn
  task auto_scn;
    cmd(ACTV, 2'h3, 1'b0, 10'h000);
    tick(2);
    cmd(RD, 2'h3, 1'b1, 10'h008);
    tick(1);
    chk(32'(bank_state_o[7:6]), 32'(lpddr_bank_pkg::BANK_ACTIVE), "auto");
    tick(1);
    chk(32'(bank_state_o[7:6]), 32'(lpddr_bank_pkg::BANK_PRECHARGING), "auto");
  endtask : auto_scn
  task end_of_test;
    if (fails == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  initial begin
    {ref_clk_i, arst_n_i, chip_select_n_i, go, bank_select_low_i, bank_select_high_i} = '0;
    {precharge_select_bit_i, col_addr_i, base, masks} = '0;
    {row_strobe_n_i, col_strobe_n_i, write_enable_n_i} = lpddr_bank_pkg::PIN_NOP;
    clock_enable_i = 1'b1;
    repeat (10) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    bank_scn;
    write_scn;
    trunc_scn;
    refresh_scn;
    auto_scn;
    end_of_test;
  end
  initial begin
    repeat (2000) @(posedge ref_clk_i);
    fails++;
    end_of_test;
  end
endmodule : lpddr_write_precharge_refresh_tb
`default_nettype wire
